// ---- rtl/fault_supervisor_consts.vh ----
// Constants for the flyback fault supervisor
`ifndef FAULT_SUPERVISOR_CONSTS_VH
`define FAULT_SUPERVISOR_CONSTS_VH
`define CLK_FREQ_HZ 50000000
`define FILT_TIME_US 125
`define FILT_CYCLES ((`FILT_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define BROWNOUT_TIME_MS 40
`define BROWNOUT_CYCLES (`BROWNOUT_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define FILT_PWM_PERIODS 2
`define VARIANT_A 2'h0
`define VARIANT_B 2'h1
`define VARIANT_C 2'h2
`define CNT_W 24
`endif

// ---- rtl/flyback_fault_supervisor.v ----
// Fault supervisor for a primary-side flyback controller
`timescale 1ns/1ps
`include "fault_supervisor_consts.vh"
module flyback_fault_supervisor #(
   parameter [1:0] VARIANT = `VARIANT_A,
   parameter FILT_CYCLES = `FILT_CYCLES,
   parameter BROWNOUT_CYCLES = `BROWNOUT_CYCLES,
   parameter RESET_LONG_CYCLES = 50000,
   parameter RESET_SHORT_CYCLES = 5000
)(
   input wire clk,
   input wire rst,
   input wire pwm_period_tick,
   input wire startup_req,
   input wire pin_check_done,
   input wire voltage_sense_pin_fault,
   input wire gate_drive_pin_fault,
   input wire current_sense_pin_fault,
   input wire diag_fault,
   input wire supply_ov,
   input wire supply_uv,
   input wire output_ov,
   input wire brownout,
   input wire overtemp_trip,
   input wire temp_below_hyst,
   input wire overload_timeout,
   input wire shutdown_pin_low,
   input wire shutdown_pin_wake,
   input wire low_power_req,
   input wire sleep_active,
   input wire vdd_at_reset_level,
   input wire ac_present,
   output reg pwm_enable_q,
   output reg pin_check_run_q,
   output reg shutdown_pullup_en_q,
   output reg wake_now_q,
   output reg low_power_q,
   output reg vdd_discharge_q,
   output reg vdd_latch_reg_q,
   output reg fault_latched_q,
   output reg fault_restart_q
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_CHECK = 3'h1;
   localparam [2:0] ST_RUN = 3'h2;
   localparam [2:0] ST_WAIT = 3'h3;
   localparam [2:0] ST_DISCH = 3'h4;
   localparam [2:0] ST_LATCH = 3'h5;
   localparam [2:0] ST_OTWAIT = 3'h6;
   localparam NF = 6;

   reg [2:0] state_q;
   reg [2:0] state_d;

   // Auto-restart states, also decoded for the restart flag
   function is_restart;
      input [2:0] st;
      begin
         is_restart = (st == ST_WAIT) || (st == ST_DISCH) ||
                      (st == ST_OTWAIT);
      end
   endfunction

   // States that park the controller in low-power mode
   function is_low_power;
      input [2:0] st;
      begin
         is_low_power = (st == ST_WAIT) || (st == ST_LATCH) ||
                        (st == ST_OTWAIT);
      end
   endfunction

   wire is_a = (VARIANT == `VARIANT_A);
   wire is_c = (VARIANT == `VARIANT_C);

   // Filtered sources: 0 sup ov,1 sup uv,2 out ov,3 sd low,4 ot,5 brownout
   wire [NF-1:0] raw;
   assign raw = {brownout, overtemp_trip, shutdown_pin_low, output_ov,
                 supply_uv, supply_ov};
   reg [NF-1:0] hit;
   wire [NF-1:0] ok;
   reg [`CNT_W-1:0] cnt_q [0:NF-1];
   reg [1:0] per_q [0:NF-1];

   genvar g;
   generate
      for (g = 0; g < NF; g = g + 1)
      begin : filt
         wire [`CNT_W-1:0] lim;
         assign lim = (g == NF-1) ? BROWNOUT_CYCLES[`CNT_W-1:0] :
                      FILT_CYCLES[`CNT_W-1:0];
         wire per_ok = (g == NF-1) ||
                       (per_q[g] >= `FILT_PWM_PERIODS);
         // Persistence time counter
         always @(posedge clk)
         begin
            if (rst || !raw[g] || state_q != ST_RUN)
               cnt_q[g] <= {`CNT_W{1'b0}};
            else if (cnt_q[g] < lim)
               cnt_q[g] <= cnt_q[g] + 1'b1;
         end

         // Persistence PWM period counter
         always @(posedge clk)
         begin
            if (rst || !raw[g] || state_q != ST_RUN)
               per_q[g] <= 2'h0;
            else if (pwm_period_tick && per_q[g] < `FILT_PWM_PERIODS)
               per_q[g] <= per_q[g] + 2'h1;
         end

         assign ok[g] = raw[g] && (cnt_q[g] >= lim) && per_ok;
      end
   endgenerate

   reg [31:0] tmr_q;
   reg latch_f;
   reg any_f;
   reg any_pin;
   reg pin_latch;

   always @*
   begin
      hit = ok;
      any_pin = voltage_sense_pin_fault || gate_drive_pin_fault ||
                current_sense_pin_fault || diag_fault;
      pin_latch = !is_c && any_pin;
      any_f = |hit || (is_a && overload_timeout);
      latch_f = is_a && (hit[0] || hit[2] || hit[3] || hit[4]);
   end

   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (startup_req && ac_present)
               state_d = ST_CHECK;
         ST_CHECK:
            if (pin_check_done)
            begin
               if (pin_latch)
                  state_d = ST_LATCH;
               else if (any_pin)
                  state_d = ST_WAIT;
               else
                  state_d = ST_RUN;
            end
         ST_RUN:
            if (latch_f)
               state_d = ST_LATCH;
            else if (hit[4])
               state_d = ST_OTWAIT;
            else if (any_f)
               state_d = ST_WAIT;
         ST_OTWAIT:
            if (temp_below_hyst)
               state_d = ST_WAIT;
         ST_WAIT:
            if (tmr_q == 32'h0)
               state_d = ST_DISCH;
         ST_DISCH:
            if (vdd_at_reset_level)
               state_d = ST_IDLE;
         ST_LATCH:
            if (!ac_present)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   // State register
   always @(posedge clk)
   begin
      if (rst)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // Reset wait timer, short for brownout
   always @(posedge clk)
   begin
      if (rst)
         tmr_q <= 32'h0;
      else if (state_d == ST_WAIT && state_q != ST_WAIT)
         tmr_q <= (state_q == ST_RUN && hit[5]) ?
                  RESET_SHORT_CYCLES : RESET_LONG_CYCLES;
      else if (tmr_q != 32'h0)
         tmr_q <= tmr_q - 32'h1;
   end

   always @(posedge clk)
   begin
      if (rst)
         pwm_enable_q <= 1'b0;
      else
         pwm_enable_q <= (state_d == ST_RUN);
   end

   always @(posedge clk)
   begin
      if (rst)
         pin_check_run_q <= 1'b0;
      else
         pin_check_run_q <= (state_d == ST_CHECK);
   end

   // Pull-up dropped only while running with low_power_req set
   always @(posedge clk)
   begin
      if (rst)
         shutdown_pullup_en_q <= 1'b1;
      else
         shutdown_pullup_en_q <= !(state_d == ST_RUN && low_power_req);
   end

   always @(posedge clk)
   begin
      if (rst)
         wake_now_q <= 1'b0;
      else
         wake_now_q <= state_q == ST_RUN && low_power_req && sleep_active &&
                       shutdown_pin_wake;
   end

   always @(posedge clk)
   begin
      if (rst)
         low_power_q <= 1'b0;
      else
         low_power_q <= is_low_power(state_d);
   end

   always @(posedge clk)
   begin
      if (rst)
         vdd_discharge_q <= 1'b0;
      else
         vdd_discharge_q <= (state_d == ST_DISCH);
   end

   always @(posedge clk)
   begin
      if (rst)
         vdd_latch_reg_q <= 1'b0;
      else
         vdd_latch_reg_q <= (state_d == ST_LATCH);
   end

   always @(posedge clk)
   begin
      if (rst)
         fault_latched_q <= 1'b0;
      else
         fault_latched_q <= (state_d == ST_LATCH);
   end

   always @(posedge clk)
   begin
      if (rst)
         fault_restart_q <= 1'b0;
      else
         fault_restart_q <= is_restart(state_d);
   end
endmodule // flyback_fault_supervisor

// ---- test/fault_supervisor_sva.sv ----
// Checker for the fault supervisor
`timescale 1ns/1ps
module fault_supervisor_sva (
   input wire clk, rst, pwm_enable_q, pin_check_run_q, low_power_q,
   input wire shutdown_pullup_en_q, wake_now_q, vdd_discharge_q,
   input wire fault_latched_q, fault_restart_q, shutdown_pin_wake,
   input wire supply_ov, supply_uv, output_ov, brownout, overtemp_trip,
   input wire overload_timeout, shutdown_pin_low, pin_check_done,
   input wire voltage_sense_pin_fault, ac_present, low_power_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire any_f = supply_ov | supply_uv | output_ov | brownout
      | overtemp_trip | shutdown_pin_low;
   AST_CHECK_NO_PWM: assert property (pin_check_run_q |-> !pwm_enable_q)
      else $error("pwm during check");
   AST_FAULT_NO_PWM: assert property ((fault_latched_q | fault_restart_q)
      |-> !pwm_enable_q) else $error("pwm during fault");
   AST_FILTER_HELD: assert property ($fell(pwm_enable_q) |->
      $past(any_f, 10) || $past(overload_timeout))
      else $error("unfiltered stop");
   AST_PIN_STOP: assert property (pin_check_run_q && pin_check_done
      && voltage_sense_pin_fault |=> (fault_latched_q | fault_restart_q)
      && !pwm_enable_q) else $error("pin fault missed");
   AST_PULLUP_RUN: assert property (pwm_enable_q && !$past(low_power_req)
      |-> shutdown_pullup_en_q) else $error("pullup off");
   AST_PULLUP_LP: assert property (pwm_enable_q && $past(low_power_req)
      |-> !shutdown_pullup_en_q) else $error("pullup on");
   AST_WAKE_CAUSE: assert property (wake_now_q |-> $past(shutdown_pin_wake))
      else $error("wake without pin");
   AST_LATCH_HOLD: assert property (fault_latched_q && ac_present
      |=> fault_latched_q) else $error("latch lost");
   AST_DISCH_SAFE: assert property (vdd_discharge_q |-> !pwm_enable_q
      && !fault_latched_q) else $error("bad discharge");
endmodule // fault_supervisor_sva
bind flyback_fault_supervisor fault_supervisor_sva u_sva (.*);

// ---- test/testbench.sv ----
// Testbench for the fault supervisor
`timescale 1ns/1ps
module testbench;
   reg clk = 1'b0, rst = 1'b1, tick = 1'b0, go = 1'b0, done = 1'b0;
   reg [3:0] pf = 4'h0;
   reg [6:0] ff = 7'h00;
   reg lp = 1'b0, slp = 1'b0, ac = 1'b1, ok = 1'b0, droop = 1'b0;
   reg hyst = 1'b1, vrl = 1'b1;
   wire wake, pwm, run, pu, wk, lpo, dis, lat, rs, vlr;
   integer mismatches = 0, comparisons = 0, cyc = 0, i, n;
   always #10 clk = ~clk;
   always @(negedge clk)
   begin
      cyc = cyc + 1;
      tick <= (cyc % 4 == 0);
      if (cyc > 20000)
      begin
         mismatches = mismatches + 1;
         final_report;
      end
   end
   wake_monitor_model wm (.clk(clk), .out_ok(ok), .droop(droop), .wake(wake));
   flyback_fault_supervisor #(.FILT_CYCLES(20), .BROWNOUT_CYCLES(50),
      .RESET_LONG_CYCLES(30), .RESET_SHORT_CYCLES(10)) uut (.clk(clk),
      .rst(rst), .pwm_period_tick(tick), .startup_req(go),
      .pin_check_done(done), .voltage_sense_pin_fault(pf[0]),
      .gate_drive_pin_fault(pf[1]), .current_sense_pin_fault(pf[2]),
      .diag_fault(pf[3]), .supply_ov(ff[0]), .supply_uv(ff[1]),
      .output_ov(ff[2]), .brownout(ff[3]), .overtemp_trip(ff[4]),
      .overload_timeout(ff[5]), .shutdown_pin_low(ff[6]),
      .temp_below_hyst(hyst), .shutdown_pin_wake(wake), .low_power_req(lp),
      .sleep_active(slp), .vdd_at_reset_level(vrl), .ac_present(ac),
      .pwm_enable_q(pwm), .pin_check_run_q(run), .shutdown_pullup_en_q(pu),
      .wake_now_q(wk), .low_power_q(lpo), .vdd_discharge_q(dis),
      .vdd_latch_reg_q(vlr), .fault_latched_q(lat), .fault_restart_q(rs));
   task chk(input [1:0] seen, input [1:0] exp);
   begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   end
   endtask
   task w(input integer k);
      repeat (k) @(negedge clk);
   endtask
   task start(input [3:0] p);
   begin
      go = 1'b1;
      w(2);
      go = 1'b0;
      chk(run, 1'b1);
      pf = p;
      done = 1'b1;
      w(1);
      done = 1'b0;
      pf = 4'h0;
      w(1);
   end
   endtask
   task unlatch;
   begin
      ac = 1'b0;
      w(3);
      ac = 1'b1;
      w(3);
      chk(lat, 1'b0);
   end
   endtask
   task t_pin;
   begin
      for (i = 0; i < 4; i = i + 1)
      begin
         start(4'h1 << i);
         chk({pwm, lat}, 2'b01);
         chk(vlr, 1'b1);
         unlatch;
      end
      $display("pin faults done");
   end
   endtask
   task t_filt;
   begin
      for (i = 0; i < 7; i = i + 1)
      begin
         n = (i == 3) ? 50 : 20;
         start(4'h0);
         ff = 7'h01 << i;
         if (i != 5)
         begin
            w(n - 5);
            ff = 7'h00;
            w(3);
            ff = 7'h01 << i;
            w(n - 1);
            chk(pwm, 1'b1);
            w(4);
         end
         w(2);
         ff = 7'h00;
         chk(pwm, 1'b0);
         chk({lat, rs}, i % 2 ? 2'b01 : 2'b10);
         if (lat === 1'b1)
            unlatch;
         else
         begin
            vrl = 1'b0;
            for (n = 0; n < 200 && dis !== 1'b1; n = n + 1)
               w(1);
            chk(dis, 1'b1);
            w(3);
            chk(dis, 1'b1);
            vrl = 1'b1;
            w(5);
         end
      end
      $display("filtered faults done");
   end
   endtask
   task t_wake;
   begin
      start(4'h0);
      lp = 1'b1;
      slp = 1'b1;
      w(3);
      chk({lpo, pu}, 2'b00);
      ok = 1'b1;
      droop = 1'b1;
      w(3);
      chk(wk, 1'b1);
      droop = 1'b0;
      lp = 1'b0;
      slp = 1'b0;
      w(3);
      chk(pu, 1'b1);
      $display("wake done");
   end
   endtask
   task final_report;
   begin
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   initial
   begin
      w(8);
      rst = 1'b0;
      w(1);
      t_pin;
      t_filt;
      t_wake;
      final_report;
   end
endmodule // testbench

// ---- test/wake_monitor_model.sv ----
// Secondary-side wake monitor model
`timescale 1ns/1ps
module wake_monitor_model (
   input wire clk,
   input wire out_ok,
   input wire droop,
   output reg wake
);
   initial wake = 1'b0;
   // Wake held low until output is above enable level
   always @(negedge clk) wake <= out_ok & droop;
endmodule // wake_monitor_model
